// ==== pkg/ssc_pkg.sv ====
// constants of the synchronous serial control and clock block
package ssc_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] SSC_IDX_BUF0  = 14'hf90;
  localparam logic [13:0] SSC_IDX_CTRL1 = 14'hf98;
  localparam logic [13:0] SSC_IDX_CTRL2 = 14'hf99;
  localparam logic [7:0]  SSC_CTRL1_RST = 8'h00;
  localparam logic [7:0]  SSC_CTRL2_RST = 8'h00;
  // control one fields
  localparam int SSC_RUN_BIT   = 7;
  localparam int SSC_ABORT_BIT = 6;
  localparam int SSC_MODE_LSB  = 3;
  localparam int SSC_CLK_LSB   = 0;
  // control two fields
  localparam int SSC_WAIT_LSB  = 3;
  localparam int SSC_COUNT_LSB = 0;
  // status fields
  localparam int SSC_ACT_BIT   = 7;
  localparam int SSC_SHIFT_BIT = 6;
  // transfer modes
  localparam logic [2:0] SSC_M_TX8   = 3'h0;
  localparam logic [2:0] SSC_M_TX4   = 3'h2;
  localparam logic [2:0] SSC_M_TRX8  = 3'h4;
  localparam logic [2:0] SSC_M_RX8   = 3'h5;
  localparam logic [2:0] SSC_M_RX4   = 3'h6;
  // clock selections
  localparam logic [2:0] SSC_C_SLOW  = 3'h0;
  localparam logic [2:0] SSC_C_FAST  = 3'h5;
  localparam logic [2:0] SSC_C_RSV   = 3'h6;
  localparam logic [2:0] SSC_C_EXT   = 3'h7;
  // divider exponents: code 000 and code 001 on the high-frequency clock
  localparam int SSC_DIV_SLOW_EXP = 13;
  localparam int SSC_DIV_C1_EXP   = 8;
  localparam int SSC_FS_EXP       = 5;
  // half ticks in one 8-bit word time
  localparam logic [6:0] SSC_WORD_HALVES = 7'h10;
  typedef enum logic [1:0] {SSC_IDLE, SSC_SHIFT, SSC_HOLD, SSC_GAP} ssc_state_t;
endpackage

// ==== hw/ssc_ctrl.sv ====
// serial control, status, clock and shift engine with word buffer
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - run bit starts, clearing it stops transfer
// - abort bit stops at once, then self-clears
// - decode five transfer modes, others reserved
// - clock code 111 takes external pin clock
// - six internal divider rates, slow modes 000
// - wait field stretches internal-clock transmit/receive frame to 1,2,4,8
// - word count selects one to eight words
// - nibble mode uses low half, zeros upper
// - words run from lowest buffer upward
// - programmed word count is never altered
// - status bit 7 shows transfer active
// - status bit 6 shows shift active
// - active clears when run is cleared or on abort, not at burst end
// - internal clock drives pin, high at start
// - internal clock waits for lagging buffer access
// - transmit on falling, receive on rising edge
// - each word goes least significant bit first
// - burst end raises serial interrupt pulse
module ssc_ctrl import ssc_pkg::*; #(
  parameter int BUF_WORDS = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        fs_tick_i,
  input  wire logic        low_speed_mode_i,
  input  wire logic        prescaler_tap_select_i,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             serial_irq_o
);
  if (BUF_WORDS != 8) begin : g_chk
    $error("ssc_ctrl: word count field serves exactly eight words");
  end

  logic [7:0]  ctrl1_q, ctrl2_q;
  logic        abort_q;
  logic [7:0]  buf_q [BUF_WORDS];
  ssc_state_t  state_q;
  logic [2:0]  widx_q, bits_q;
  logic [7:0]  tx_sr_q, rx_sr_q;
  logic        sck_q, so_q, irq_q, ack_q;
  logic [12:0] div_q;
  logic [3:0]  fs_cnt_q;
  logic [6:0]  gap_q;
  logic [2:0]  sck_sync_q, si_sync_q;
  logic        buf_acc_q;

  // bus decode
  logic        req, wr, rd;
  logic [13:0] idx;
  logic        hit_buf, hit_c1, hit_c2;
  assign req     = cyc_i && stb_i && !ack_q;
  assign idx     = adr_i[15:2];
  assign wr      = req && we_i && sel_i[0];
  assign rd      = req && !we_i;
  assign hit_buf = idx[13:3] == SSC_IDX_BUF0[13:3];
  assign hit_c1  = idx == SSC_IDX_CTRL1;
  assign hit_c2  = idx == SSC_IDX_CTRL2;

  // field views
  logic [2:0] mode, clk_sel, count;
  logic [1:0] wait_sel;
  logic       run, is_tx, is_rx, nib, ext, tick, fall, rise;
  assign run      = ctrl1_q[SSC_RUN_BIT];
  assign mode     = ctrl1_q[SSC_MODE_LSB +: 3];
  assign clk_sel  = ctrl1_q[SSC_CLK_LSB +: 3];
  assign wait_sel = ctrl2_q[SSC_WAIT_LSB +: 2];
  assign count    = ctrl2_q[SSC_COUNT_LSB +: 3];
  always_comb begin
    is_tx   = 1'b0;
    is_rx   = 1'b0;
    nib     = 1'b0;
    case (mode)
      SSC_M_TX8:  is_tx = 1'b1;
      SSC_M_TX4:  begin is_tx = 1'b1; nib = 1'b1; end
      SSC_M_TRX8: begin is_tx = 1'b1; is_rx = 1'b1; end
      SSC_M_RX8:  is_rx = 1'b1;
      SSC_M_RX4:  begin is_rx = 1'b1; nib = 1'b1; end
      default:    is_tx = 1'b0; // reserved codes never start
    endcase
  end
  assign ext = clk_sel == SSC_C_EXT;

  // pin synchronisers; only stage 2 and later are read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_sync_q <= 3'h7;
      si_sync_q  <= 3'h0;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      si_sync_q  <= {si_sync_q[1:0], si_i};
    end
  end

  // internal divider: free running, so the first half period may be short
  logic [12:0] mask;
  always_comb begin
    mask = 13'h0;
    if (clk_sel >= 3'h1 && clk_sel <= SSC_C_FAST) begin
      mask = 13'((13'h1 << (SSC_DIV_C1_EXP - 1 - (int'(clk_sel) - 1))) - 13'h1);
    end else begin
      mask = 13'((13'h1 << (SSC_DIV_SLOW_EXP - 1)) - 13'h1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q    <= 13'h0;
      fs_cnt_q <= 4'h0;
    end else begin
      div_q <= div_q + 13'h1;
      if (fs_tick_i) begin
        fs_cnt_q <= fs_cnt_q + 4'h1;
      end
    end
  end
  always_comb begin
    tick = 1'b0;
    if (clk_sel == SSC_C_SLOW && (low_speed_mode_i || prescaler_tap_select_i)) begin
      tick = fs_tick_i && fs_cnt_q == 4'((1 << (SSC_FS_EXP - 1)) - 1);
    end else if (clk_sel == SSC_C_SLOW || (clk_sel <= SSC_C_FAST && !low_speed_mode_i)) begin
      tick = (div_q & mask) == mask;
    end
  end
  // shift edges: internal from the divider, external from the synced pin
  assign fall = ext ? (sck_sync_q[2] && !sck_sync_q[1]) : (tick && sck_q);
  assign rise = ext ? (!sck_sync_q[2] && sck_sync_q[1]) : (tick && !sck_q);

  // control registers and bus answer
  logic abort_wr, start_wr, start_ok, last_bit, last_word, gap_need;
  assign abort_wr = wr && hit_c1 && dat_i[SSC_ABORT_BIT];
  // the fields of the starting write decide, so a reserved code in that same write is refused
  assign start_ok = dat_i[SSC_MODE_LSB +: 3] inside {SSC_M_TX8, SSC_M_TX4, SSC_M_TRX8, SSC_M_RX8, SSC_M_RX4}
                    && dat_i[SSC_CLK_LSB +: 3] != SSC_C_RSV;
  assign start_wr = wr && hit_c1 && dat_i[SSC_RUN_BIT] && !dat_i[SSC_ABORT_BIT] && start_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_q <= SSC_CTRL1_RST;
      ctrl2_q <= SSC_CTRL2_RST;
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_wr;
      if (wr && hit_c1) begin
        ctrl1_q <= dat_i[7:0];
      end else if (abort_q) begin
        ctrl1_q[SSC_ABORT_BIT] <= 1'b0;
      end
      if (wr && hit_c2) begin
        ctrl2_q <= dat_i[7:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_q <= req;
      dat_o <= 32'h0;
      if (rd && hit_buf) begin
        dat_o <= {24'h0, buf_q[idx[2:0]]};
      end else if (rd && hit_c2) begin
        dat_o <= {24'h0, state_q != SSC_IDLE, state_q == SSC_SHIFT, 6'h0};
      end
    end
  end
  assign ack_o = ack_q;

  // shift engine
  assign last_bit  = bits_q == (nib ? 3'h3 : 3'h7);
  assign last_word = widx_q == count;
  assign gap_need  = !ext && mode == SSC_M_TRX8 && wait_sel != 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SSC_IDLE;
      widx_q  <= 3'h0;
      bits_q  <= 3'h0;
      tx_sr_q <= 8'h0;
      rx_sr_q <= 8'h0;
      sck_q   <= 1'b1;
      so_q    <= 1'b1;
      irq_q   <= 1'b0;
      gap_q   <= 7'h0;
    end else begin
      irq_q <= 1'b0;
      if (abort_wr) begin
        state_q <= SSC_IDLE;
        sck_q   <= 1'b1;
      end else begin
        case (state_q)
          SSC_IDLE: begin
            if (start_wr) begin
              state_q <= SSC_SHIFT;
              widx_q  <= 3'h0;
              bits_q  <= 3'h0;
              sck_q   <= 1'b1;
              tx_sr_q <= buf_q[0];
            end
          end
          SSC_SHIFT: begin
            if (fall) begin
              sck_q   <= 1'b0;
              so_q    <= is_tx ? tx_sr_q[0] : 1'b1;
              tx_sr_q <= {1'b0, tx_sr_q[7:1]};
            end else if (rise) begin
              sck_q   <= 1'b1;
              rx_sr_q <= {si_sync_q[2], rx_sr_q[7:1]};
              bits_q  <= bits_q + 3'h1;
              if (last_bit) begin
                bits_q <= 3'h0;
                widx_q <= widx_q + 3'h1;
                if (last_word) begin
                  irq_q  <= 1'b1;
                  widx_q <= 3'h0;
                end
                if (!run) begin
                  state_q <= SSC_IDLE;
                end else if (last_word && !ext) begin
                  state_q <= SSC_HOLD;
                end else if (gap_need) begin
                  state_q <= SSC_GAP;
                  gap_q   <= 7'(((7'h1 << wait_sel) - 7'h1) * SSC_WORD_HALVES);
                end else begin
                  tx_sr_q <= buf_q[last_word ? 3'h0 : widx_q + 3'h1];
                end
              end
            end
          end
          SSC_HOLD: begin
            // clock parked high until software touches the buffer
            if (!run) begin
              state_q <= SSC_IDLE;
            end else if (buf_acc_q) begin
              state_q <= gap_need ? SSC_GAP : SSC_SHIFT;
              gap_q   <= 7'(((7'h1 << wait_sel) - 7'h1) * SSC_WORD_HALVES);
              tx_sr_q <= buf_q[0];
            end
          end
          SSC_GAP: begin
            if (!run) begin
              state_q <= SSC_IDLE;
            end else if (tick) begin
              gap_q <= gap_q - 7'h1;
              if (gap_q == 7'h1) begin
                state_q <= SSC_SHIFT;
                tx_sr_q <= buf_q[widx_q];
              end
            end
          end
          default: state_q <= SSC_IDLE;
        endcase
      end
    end
  end

  // buffer: bus writes and received words share one write port
  logic rx_store, buf_touch;
  assign rx_store  = state_q == SSC_SHIFT && rise && last_bit && is_rx && !abort_wr;
  assign buf_touch = hit_buf && ((is_tx && !is_rx && wr) || (is_rx && rd));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_q[i] <= 8'h0;
      end
      buf_acc_q <= 1'b0;
    end else begin
      buf_acc_q <= buf_acc_q && state_q != SSC_HOLD;
      if (state_q == SSC_IDLE || state_q == SSC_SHIFT && rise && last_bit && last_word) begin
        buf_acc_q <= 1'b0;
      end
      if (buf_touch) begin
        buf_acc_q <= 1'b1; // an access in the clearing cycle still counts
      end
      if (wr && hit_buf) begin
        buf_q[idx[2:0]] <= dat_i[7:0];
      end
      if (rx_store) begin
        buf_q[widx_q] <= nib ? {4'h0, si_sync_q[2], rx_sr_q[7:5]} : {si_sync_q[2], rx_sr_q[7:1]};
      end
    end
  end

  assign sck_o        = sck_q;
  assign sck_oe_o     = !ext && clk_sel != SSC_C_RSV;
  assign so_o         = so_q;
  assign serial_irq_o = irq_q;

  abort_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) abort_wr |=> state_q == SSC_IDLE)
    else $error("abort did not end the transfer");
  abort_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_wr ##1 !(wr && hit_c1) |=> !ctrl1_q[SSC_ABORT_BIT])
    else $error("abort bit not self-cleared");
  start_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SSC_IDLE && start_wr |=> state_q == SSC_SHIFT && sck_o)
    else $error("start did not begin a transfer with clock high");
  reserved_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SSC_IDLE && wr && hit_c1 && !start_ok |=> state_q == SSC_IDLE)
    else $error("reserved code started a transfer");
  count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_c2) |=> ctrl2_q == $past(ctrl2_q))
    else $error("word count changed without a write");
  nibble_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_store && nib && !(wr && hit_buf) |=> buf_q[$past(widx_q)][7:4] == 4'h0)
    else $error("nibble receive left upper bits set");
  ext_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) ext |-> !sck_oe_o)
    else $error("pin driven with external clock");
  lsb_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SSC_SHIFT && fall && is_tx && !abort_wr |=> so_o == $past(tx_sr_q[0]))
    else $error("transmit bit not taken from bit zero");
  irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_irq_o |-> $past(widx_q) == $past(count) ##1 !serial_irq_o)
    else $error("interrupt not at burst end or not a pulse");
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && hit_c2 |=> dat_o[SSC_ACT_BIT] == ($past(state_q) != SSC_IDLE)
      && dat_o[SSC_SHIFT_BIT] == ($past(state_q) == SSC_SHIFT))
    else $error("status read mismatched engine state");
endmodule // ssc_ctrl
`default_nettype wire

// ==== testbench/ssc_peer.sv ====
// external synchronous serial peer: clock source, data source and data sink
`timescale 1ns/100ps
`default_nettype none
module ssc_peer (
  input  wire logic        clk_i,
  input  wire logic        sck_oe_i,
  input  wire logic        sck_dev_i,
  input  wire logic        so_i,
  input  wire logic        ld_i,
  input  wire logic [15:0] tx_bits_i,
  input  wire logic        ext_go_i,
  output logic             sck_pin_o,
  output logic             si_o,
  output logic [15:0]      rx_bits_o
);
  logic [15:0] tx_q = 16'hffff;
  logic [4:0]  edge_cnt_q = 5'h0;
  logic [2:0]  ph_q = 3'h0;
  logic        ext_sck_q = 1'b1;
  logic        pin_q = 1'b1;
  logic [5:0]  idle_q = 6'h0;
  logic        si_q = 1'b1;
  logic [15:0] rx_q = 16'h0;
  // a pin the device does not drive carries our clock, which idles high between frames
  assign sck_pin_o = sck_oe_i ? sck_dev_i : ext_sck_q;
  assign si_o      = si_q;
  assign rx_bits_o = rx_q;
  always @(posedge clk_i) begin
    if (ext_go_i) begin
      edge_cnt_q <= 5'h10;
      ph_q <= 3'h0;
    end else if (edge_cnt_q != 5'h0) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h5) begin // six cycles per level, above the minimum width and rate
        ph_q <= 3'h0;
        ext_sck_q <= ~ext_sck_q;
        edge_cnt_q <= edge_cnt_q - 5'h1;
      end
    end
  end
  always @(posedge clk_i) begin
    pin_q <= sck_pin_o;
    if (ld_i) tx_q <= tx_bits_i;
    if (pin_q && !sck_pin_o) begin
      si_q <= tx_q[0];
      tx_q <= {1'b1, tx_q[15:1]};
      idle_q <= 6'h0;
    end else if (idle_q == 6'h3f) begin
      // stale data line wanders so a late sample cannot pass by luck
      si_q <= ~si_q;
    end else begin
      idle_q <= idle_q + 6'h1;
    end
    if (!pin_q && sck_pin_o) rx_q <= {so_i, rx_q[15:1]};
  end
endmodule // ssc_peer
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the serial control and clock block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ssc_pkg::*;
  localparam logic [15:0] A_BUF = {SSC_IDX_BUF0, 2'b00};
  localparam logic [15:0] A_C1  = {SSC_IDX_CTRL1, 2'b00};
  localparam logic [15:0] A_C2  = {SSC_IDX_CTRL2, 2'b00};
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, serial_irq_o;
  logic [15:0] adr_i, tx_bits, rx_bits;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i;
  logic        sck_o, sck_oe_o, so_o, sck_pin, si_pin, ld, ext_go;
  logic        fs_tick, low_spd, tap;
  int          error_cnt, check_count, last_wait;
  ssc_ctrl #(.BUF_WORDS(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .fs_tick_i(fs_tick),
    .low_speed_mode_i(low_spd), .prescaler_tap_select_i(tap), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .si_i(si_pin), .so_o(so_o), .serial_irq_o(serial_irq_o));
  ssc_peer peer (.clk_i(clk_i), .sck_oe_i(sck_oe_o), .sck_dev_i(sck_o), .so_i(so_o), .ld_i(ld),
    .tx_bits_i(tx_bits), .ext_go_i(ext_go), .sck_pin_o(sck_pin), .si_o(si_pin), .rx_bits_o(rx_bits));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ack is judged on its value before the edge, so the master never races the slave
  task automatic wb(input logic wr, input logic [15:0] adr, input logic [7:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= adr; dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask
  task automatic wr(input logic [15:0] adr, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, adr, d, x);
  endtask
  task automatic rdchk(input logic [15:0] adr, input logic [7:0] exp);
    logic [31:0] x;
    wb(1'b0, adr, 8'h0, x);
    chk(x, {24'h0, exp});
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (serial_irq_o !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    last_wait = n;
    if (n >= 2000) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask
  function automatic logic [7:0] c1(input logic run, input logic ab, input logic [2:0] m, input logic [2:0] c);
    return {run, ab, m, c};
  endfunction
  task automatic t_reset;
    rdchk(A_C2, 8'h00);
    rdchk(A_C1, 8'h00);
    rdchk(16'h0010, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_tx8;
    wr(A_BUF, 8'ha5);
    wr(A_BUF + 16'h4, 8'h3c);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    wr(A_C2, 8'h01);
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TX8, SSC_C_FAST));
    chk({30'h0, sck_oe_o, sck_pin}, 32'h3);
    wait_irq();
    rdchk(A_C2, 8'h80);
    chk({16'h0, rx_bits}, 32'h3ca5);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    rdchk(A_C2, 8'h00);
    $display("test tx8 done");
  endtask
  task automatic t_rx4;
    @(posedge clk_i);
    tx_bits <= 16'hff69;
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_RX4, SSC_C_FAST));
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_RX4, SSC_C_FAST));
    wait_irq();
    rdchk(A_BUF, 8'h09);
    rdchk(A_BUF + 16'h4, 8'h06);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_RX4, SSC_C_FAST));
    rdchk(A_C2, 8'h00);
    $display("test rx4 done");
  endtask
  task automatic t_ext;
    wr(A_BUF, 8'h5a);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_EXT));
    wr(A_C2, 8'h00);
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TX8, SSC_C_EXT));
    chk({31'h0, sck_oe_o}, 32'h0);
    ext_go <= 1'b1;
    @(posedge clk_i);
    ext_go <= 1'b0;
    wait_irq();
    chk({24'h0, rx_bits[15:8]}, 32'h5a);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    rdchk(A_C2, 8'h00);
    $display("test external clock done");
  endtask
  task automatic t_reserved;
    wr(A_C1, c1(1'b1, 1'b0, 3'h1, SSC_C_FAST));
    rdchk(A_C2, 8'h00);
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TX8, SSC_C_RSV));
    rdchk(A_C2, 8'h00);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    $display("test reserved codes done");
  endtask
  // two full-duplex words, one word time of wait between them: 48 half periods of 8 cycles
  task automatic t_trx;
    @(posedge clk_i);
    tx_bits <= 16'hc3e1;
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
    wr(A_BUF, 8'h96);
    wr(A_BUF + 16'h4, 8'h0f);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TRX8, SSC_C_FAST));
    wr(A_C2, 8'h09);
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TRX8, SSC_C_FAST));
    wait_irq();
    chk(32'(last_wait >= 377 && last_wait <= 384), 32'h1);
    rdchk(A_BUF, 8'he1);
    rdchk(A_BUF + 16'h4, 8'hc3);
    chk({16'h0, rx_bits}, 32'h0f96);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TRX8, SSC_C_FAST));
    rdchk(A_C2, 8'h00);
    $display("test transmit receive done");
  endtask
  // low-frequency source: 16 half periods of 16 cycles; in low-speed mode fast codes must not tick
  task automatic t_slow;
    @(posedge clk_i);
    fs_tick <= 1'b1;
    tap <= 1'b1;
    wr(A_BUF, 8'hc6);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_SLOW));
    wr(A_C2, 8'h00);
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TX8, SSC_C_SLOW));
    wait_irq();
    chk(32'(last_wait >= 241 && last_wait <= 256), 32'h1);
    tap <= 1'b0;
    low_spd <= 1'b1;
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    wr(A_C1, c1(1'b1, 1'b0, SSC_M_TX8, SSC_C_FAST));
    repeat (40) @(posedge clk_i);
    rdchk(A_C2, 8'hc0);
    chk({31'h0, sck_pin}, 32'h1);
    chk({24'h0, rx_bits[15:8]}, 32'hc6);
    wr(A_C1, c1(1'b0, 1'b1, SSC_M_TX8, SSC_C_FAST));
    low_spd <= 1'b0;
    fs_tick <= 1'b0;
    $display("test slow clock done");
  endtask
  initial begin
    rst_i = 1'b1; we_i = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; adr_i = 16'h0; dat_i = 32'h0;
    sel_i = 4'hf; ld = 1'b0; ext_go = 1'b0; tx_bits = 16'hffff; error_cnt = 0; check_count = 0;
    fs_tick = 1'b0; low_spd = 1'b0; tap = 1'b0; last_wait = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx8();
    t_rx4();
    t_ext();
    t_reserved();
    t_trx();
    t_slow();
    close_out();
  end
endmodule // tb
`default_nettype wire
